//--- design/irf_bank.sv
/*
  input receiver and feedback configuration bank: two 8-bit registers
  and the decoded controls for the reference, oscillator and loop
  return receivers plus the divider bypass and feedback source.
  assumes a plain register port on the same clock; the divider words
  come from neighbouring registers of the same clock domain.
*/
// Function
// - bit 7 enables the test reference receiver
// - bit 6 sets secondary reference differential
// - bit 5 sets primary reference differential
// - bit 2 clear keeps both references powered
// - bit 4 powers secondary when control set
// - bit 3 powers primary when control set
// - bit 1 picks oscillator negative pin
// - bit 0 sets oscillator differential mode
// - bypass bits force test, feedback divide by one
// - bit 4 feeds oscillator back, else zero delay
// - bit 5 selects internal zero delay path
// - bit 2 sets loop return differential
// - bit 3 picks loop return pin, single-ended
// - bit 1 picks secondary pin, single-ended
// - bit 0 picks primary pin, single-ended
// - test divider 6 bits, zero or one bypass
// - feedback divider 10 bits, bypass overrides
`include "irf_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module irf_bank #(
  parameter int TEST_DIV_W = `IRF_TEST_DIV_W,
  parameter int FB_DIV_W = `IRF_FB_DIV_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`IRF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [TEST_DIV_W-1:0] test_div_word,
  input wire logic [FB_DIV_W-1:0] fb_div_word,
  output logic test_ref_rx_en,
  output logic pri_ref_rx_en,
  output logic pri_ref_diff,
  output logic pri_ref_pin_sel,
  output logic sec_ref_rx_en,
  output logic sec_ref_diff,
  output logic sec_ref_pin_sel,
  output logic osc_rx_diff,
  output logic osc_rx_neg_sel,
  output logic loop_return_rx_en,
  output logic loop_return_diff,
  output logic loop_return_pin_sel,
  output irf_pkg::irf_fb_src_type fb_src,
  output logic [TEST_DIV_W-1:0] test_div_eff,
  output logic [FB_DIV_W-1:0] fb_div_eff
);

  logic [7:0] rx_ctrl_reg;
  logic [7:0] zd_ctrl_reg;
  logic [7:0] rx_ctrl_next;
  logic [7:0] zd_ctrl_next;
  irf_pkg::irf_fb_src_type fb_src_next;
  logic [TEST_DIV_W-1:0] test_div_next;
  logic [FB_DIV_W-1:0] fb_div_next;
  logic rx_wr_hit;
  logic zd_wr_hit;
  logic rx_rd_hit;
  logic zd_rd_hit;

  // exact match only; an alias would let stray offsets alter the bank
  assign rx_wr_hit = reg_write && (reg_addr == `IRF_OFS_RX_CTRL);
  assign zd_wr_hit = reg_write && (reg_addr == `IRF_OFS_ZD_CTRL);
  assign rx_rd_hit = reg_read && (reg_addr == `IRF_OFS_RX_CTRL);
  assign zd_rd_hit = reg_read && (reg_addr == `IRF_OFS_ZD_CTRL);

  // register writes; no commit step, next-state logic sees the new
  // value so the decoded outputs change on the same edge as the register
  always_comb begin
    rx_ctrl_next = rx_ctrl_reg;
    zd_ctrl_next = zd_ctrl_reg;
    if (rx_wr_hit) begin
      rx_ctrl_next = reg_wdata;
    end
    if (zd_wr_hit) begin
      zd_ctrl_next = reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_ctrl_reg <= `IRF_RST_RX_CTRL;
    end else begin
      rx_ctrl_reg <= rx_ctrl_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zd_ctrl_reg <= `IRF_RST_ZD_CTRL;
    end else begin
      zd_ctrl_reg <= zd_ctrl_next;
    end
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (rx_rd_hit) begin
      reg_rdata <= rx_ctrl_reg;
    end else if (zd_rd_hit) begin
      reg_rdata <= zd_ctrl_reg;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // feedback source; bit 5 only matters in zero delay operation
  always_comb begin
    if (zd_ctrl_next[`IRF_ZD_OSC_FB]) begin
      fb_src_next = irf_pkg::IRF_FB_OSC;
    end else if (zd_ctrl_next[`IRF_ZD_INTERNAL]) begin
      fb_src_next = irf_pkg::IRF_FB_ZD_INT;
    end else begin
      fb_src_next = irf_pkg::IRF_FB_ZD_EXT;
    end
  end

  // word 0 and 1 both divide by one, so bypass presents 1
  always_comb begin
    if (zd_ctrl_next[`IRF_ZD_TEST_BYP]) begin
      test_div_next = TEST_DIV_W'(1);
    end else if (test_div_word == '0) begin
      test_div_next = TEST_DIV_W'(1);
    end else begin
      test_div_next = test_div_word;
    end
  end

  // the loop divider never sees zero, which would stall its counter
  always_comb begin
    if (zd_ctrl_next[`IRF_ZD_FB_BYP]) begin
      fb_div_next = FB_DIV_W'(1);
    end else if (fb_div_word == '0) begin
      fb_div_next = FB_DIV_W'(1);
    end else begin
      fb_div_next = fb_div_word;
    end
  end

  // test reference receiver
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      test_ref_rx_en <= 1'b0;
    end else begin
      test_ref_rx_en <= rx_ctrl_next[`IRF_RX_TEST_EN];
    end
  end

  // power control off means both references stay powered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pri_ref_rx_en <= 1'b1;
    end else begin
      pri_ref_rx_en <= !rx_ctrl_next[`IRF_RX_PD_CTRL] ||
        rx_ctrl_next[`IRF_RX_PRI_EN];
    end
  end

  // secondary power follows its own bit only under power control
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sec_ref_rx_en <= 1'b1;
    end else begin
      sec_ref_rx_en <= !rx_ctrl_next[`IRF_RX_PD_CTRL] ||
        rx_ctrl_next[`IRF_RX_SEC_EN];
    end
  end

  // primary reference mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pri_ref_diff <= 1'b0;
    end else begin
      pri_ref_diff <= rx_ctrl_next[`IRF_RX_PRI_DIFF];
    end
  end

  // secondary reference mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sec_ref_diff <= 1'b0;
    end else begin
      sec_ref_diff <= rx_ctrl_next[`IRF_RX_SEC_DIFF];
    end
  end

  // pin choice only meaningful single-ended; forced low otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pri_ref_pin_sel <= 1'b0;
    end else begin
      pri_ref_pin_sel <= !rx_ctrl_next[`IRF_RX_PRI_DIFF] &&
        zd_ctrl_next[`IRF_ZD_PRI_PIN];
    end
  end

  // secondary pin choice, same masking as the primary
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sec_ref_pin_sel <= 1'b0;
    end else begin
      sec_ref_pin_sel <= !rx_ctrl_next[`IRF_RX_SEC_DIFF] &&
        zd_ctrl_next[`IRF_ZD_SEC_PIN];
    end
  end

  // oscillator receiver mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_rx_diff <= 1'b0;
    end else begin
      osc_rx_diff <= rx_ctrl_next[`IRF_RX_OSC_DIFF];
    end
  end

  // oscillator pin choice, masked in differential mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_rx_neg_sel <= 1'b0;
    end else begin
      osc_rx_neg_sel <= !rx_ctrl_next[`IRF_RX_OSC_DIFF] &&
        rx_ctrl_next[`IRF_RX_OSC_NEG];
    end
  end

  // loop return receiver powers down for internal zero delay and for oscillator feedback
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_return_rx_en <= 1'b1;
    end else begin
      loop_return_rx_en <=
        (fb_src_next == irf_pkg::IRF_FB_ZD_EXT);
    end
  end

  // loop return receiver mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_return_diff <= 1'b0;
    end else begin
      loop_return_diff <= zd_ctrl_next[`IRF_ZD_RET_DIFF];
    end
  end

  // polarity of this pin choice is unresolved; bit passed on, masked in differential mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_return_pin_sel <= 1'b0;
    end else begin
      loop_return_pin_sel <= !zd_ctrl_next[`IRF_ZD_RET_DIFF] &&
        zd_ctrl_next[`IRF_ZD_PIN_SEL];
    end
  end

  // feedback source
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fb_src <= irf_pkg::IRF_FB_ZD_EXT;
    end else begin
      fb_src <= fb_src_next;
    end
  end

  // effective test reference divider word
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      test_div_eff <= TEST_DIV_W'(1);
    end else begin
      test_div_eff <= test_div_next;
    end
  end

  // effective loop feedback divider word
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fb_div_eff <= FB_DIV_W'(1);
    end else begin
      fb_div_eff <= fb_div_next;
    end
  end

endmodule

`default_nettype wire

//--- design/irf_consts.svh
/*
  constants for the input receiver and feedback configuration bank:
  register offsets, field positions and reset values.
  assumes inclusion by bare name from the design and bench files.
*/
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

`define IRF_ADDR_W 10
`define IRF_OFS_RX_CTRL 10'h01A
`define IRF_OFS_ZD_CTRL 10'h01B
`define IRF_RST_RX_CTRL 8'h00
`define IRF_RST_ZD_CTRL 8'h00

// receiver control fields
`define IRF_RX_TEST_EN 7
`define IRF_RX_SEC_DIFF 6
`define IRF_RX_PRI_DIFF 5
`define IRF_RX_SEC_EN 4
`define IRF_RX_PRI_EN 3
`define IRF_RX_PD_CTRL 2
`define IRF_RX_OSC_NEG 1
`define IRF_RX_OSC_DIFF 0

// test reference / zero delay fields
`define IRF_ZD_TEST_BYP 7
`define IRF_ZD_FB_BYP 6
`define IRF_ZD_INTERNAL 5
`define IRF_ZD_OSC_FB 4
`define IRF_ZD_PIN_SEL 3
`define IRF_ZD_RET_DIFF 2
`define IRF_ZD_SEC_PIN 1
`define IRF_ZD_PRI_PIN 0

`define IRF_TEST_DIV_W 6
`define IRF_FB_DIV_W 10

`endif

//--- design/irf_pkg.sv
/*
  types for the input receiver and feedback configuration bank.
  assumes nothing beyond a SystemVerilog compiler.
*/
package irf_pkg;
  typedef enum logic [1:0] {
    IRF_FB_OSC = 2'h0,
    IRF_FB_ZD_EXT = 2'h1,
    IRF_FB_ZD_INT = 2'h2
  } irf_fb_src_type;
endpackage

//--- tb/irf_bank_monitor.sv
/*
  checker for the receiver and feedback configuration bank.
  assumes binding to irf_bank, one clock, async active-low reset.
*/
`include "irf_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module irf_bank_monitor #(
  parameter int TEST_DIV_W = 6,
  parameter int FB_DIV_W = 10
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`IRF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic test_ref_rx_en,
  input wire logic pri_ref_diff,
  input wire logic pri_ref_pin_sel,
  input wire logic sec_ref_rx_en,
  input wire logic osc_rx_diff,
  input wire logic osc_rx_neg_sel,
  input wire logic loop_return_rx_en,
  input wire irf_pkg::irf_fb_src_type fb_src,
  input wire logic [TEST_DIV_W-1:0] test_div_eff,
  input wire logic [FB_DIV_W-1:0] fb_div_eff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_test_en_write:
  assert property (reg_write && reg_addr == `IRF_OFS_RX_CTRL
    |=> test_ref_rx_en == $past(reg_wdata[7])) else $error("test en bad");
  a_sec_power_write:
  assert property (reg_write && reg_addr == `IRF_OFS_RX_CTRL |=>
    sec_ref_rx_en == (!$past(reg_wdata[2]) || $past(reg_wdata[4])))
    else $error("sec power bad");
  a_osc_neg_diff:
  assert property (osc_rx_diff |-> !osc_rx_neg_sel) else $error("osc pin");
  a_pri_pin_diff:
  assert property (pri_ref_diff |-> !pri_ref_pin_sel) else $error("pri pin");
  a_loop_ret_power:
  assert property (loop_return_rx_en == (fb_src == irf_pkg::IRF_FB_ZD_EXT))
    else $error("loop return power bad");
  a_osc_fb_write:
  assert property (reg_write && reg_addr == `IRF_OFS_ZD_CTRL && reg_wdata[4]
    |=> fb_src == irf_pkg::IRF_FB_OSC) else $error("fb source bad");
  a_div_never_zero:
  assert property (test_div_eff != '0 && fb_div_eff != '0)
    else $error("divider word zero");
  a_rdata_idle:
  assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule
bind irf_bank irf_bank_monitor #(.TEST_DIV_W(TEST_DIV_W),
  .FB_DIV_W(FB_DIV_W)) irf_bank_monitor_i (.*);
`default_nettype wire

//--- tb/tb_input_receiver_feedback_config.sv
/*
  self-checking bench for irf_bank.
  assumes the design files are compiled first.
*/
`include "irf_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_input_receiver_feedback_config;
  logic clock = 0, rst_b = 0, reg_write = 0, reg_read = 0;
  logic [9:0] reg_addr = '0, fb_div_word = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, r;
  logic [5:0] test_div_word = '0, test_div_eff;
  logic [9:0] fb_div_eff;
  logic test_ref_rx_en, pri_ref_rx_en, pri_ref_diff, pri_ref_pin_sel;
  logic sec_ref_rx_en, sec_ref_diff, sec_ref_pin_sel, osc_rx_diff;
  logic osc_rx_neg_sel, loop_return_rx_en, loop_return_diff;
  logic loop_return_pin_sel;
  irf_pkg::irf_fb_src_type fb_src;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  irf_bank irf_bank_i (.*);
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  task end_of_test();
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task rd(input logic [9:0] a);
    @(posedge clock);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task t_reset();
    chk({pri_ref_rx_en, sec_ref_rx_en, test_ref_rx_en}, 3'h6);
    chk(fb_src, irf_pkg::IRF_FB_ZD_EXT);
    rd(`IRF_OFS_RX_CTRL);
    chk(r, 8'h00);
  endtask
  task t_rx();
    logic [7:0] v [4] = '{8'h04, 8'h1C, 8'hE3, 8'h4A};
    wr(`IRF_OFS_ZD_CTRL, 8'h03);
    foreach (v[i]) begin
      wr(`IRF_OFS_RX_CTRL, v[i]);
      chk(test_ref_rx_en, {v[i][7]});
      chk(sec_ref_diff, {v[i][6]});
      chk(pri_ref_diff, {v[i][5]});
      chk(sec_ref_rx_en, {~v[i][2] | v[i][4]});
      chk(pri_ref_rx_en, {~v[i][2] | v[i][3]});
      chk(osc_rx_neg_sel, {~v[i][0] & v[i][1]});
      chk(osc_rx_diff, {v[i][0]});
      chk(sec_ref_pin_sel, {~v[i][6]});
      chk(pri_ref_pin_sel, {~v[i][5]});
      rd(`IRF_OFS_RX_CTRL);
      chk(r, v[i]);
    end
  endtask
  task t_zd();
    logic [7:0] v [5] = '{8'hC0, 8'h10, 8'h30, 8'h20, 8'h0C};
    logic [1:0] e;
    test_div_word <= 6'h05; fb_div_word <= 10'h3FF;
    foreach (v[i]) begin
      wr(`IRF_OFS_ZD_CTRL, v[i]);
      chk(test_div_eff, v[i][7] ? 6'h01 : 6'h05);
      chk(fb_div_eff, v[i][6] ? 10'h001 : 10'h3FF);
      e = v[i][4] ? 2'h0 : (v[i][5] ? 2'h2 : 2'h1);
      chk(fb_src, e);
      chk(loop_return_rx_en, {~v[i][4] & ~v[i][5]});
      chk(loop_return_diff, {v[i][2]});
      chk(loop_return_pin_sel, {~v[i][2] & v[i][3]});
    end
    test_div_word <= 6'h00; fb_div_word <= 10'h000;
    wr(10'h01C, 8'hFF); // unmapped: must leave both registers alone
    chk({test_div_eff, fb_div_eff}, 16'h0401);
    rd(10'h01C);
    chk(r, 8'h00);
    rd(`IRF_OFS_ZD_CTRL);
    chk(r, 8'h0C);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    #1 t_reset();
    t_rx();
    t_zd();
    end_of_test();
  end
endmodule
`default_nettype wire
